// ### verilog/srap_pkg.sv
// Constants and types shared by the SPI register access port.
package srap_pkg;

  localparam int unsigned SRAP_BYTE_W = 8;
  localparam int unsigned SRAP_ADDR_W = 5;
  localparam int unsigned SRAP_CNT_W = 3;
  localparam int unsigned SRAP_SYNC_STAGES = 3;
  localparam int unsigned SRAP_DIR_BIT = 1;
  localparam int unsigned SRAP_ACK_BIT = 0;
  localparam int unsigned SRAP_EV_W = 5;
  localparam int unsigned SRAP_EV_ACTIVE = 0;
  localparam int unsigned SRAP_EV_CMD = 1;
  localparam int unsigned SRAP_EV_FETCH = 2;
  localparam int unsigned SRAP_EV_POP = 3;
  localparam int unsigned SRAP_EV_WR = 4;

  // Bit count seen at the fifth rising edge, when the address is complete.
  localparam logic [2:0] SRAP_ADDR_DONE_CNT = 3'h4;
  localparam logic [2:0] SRAP_BIT_LAST = 3'h7;
  localparam logic [2:0] SRAP_CNT_ZERO = 3'h0;
  localparam logic [2:0] SRAP_CNT_STEP = 3'h1;
  localparam logic SRAP_DIR_WRITE = 1'h1;
  localparam logic SRAP_FDUP_POR = 1'h0;
  localparam logic [7:0] SRAP_BYTE_ZERO = 8'h00;
  localparam logic [4:0] SRAP_ADDR_ZERO = 5'h00;

  typedef enum logic [1:0] {
    SRAP_PH_CMD = 2'h1,
    SRAP_PH_DATA = 2'h2
  } srap_phase_type;

endpackage

// ### verilog/srap_sync.sv
// Three-stage synchroniser bank with change pulses.
`timescale 1ns/1ps
module srap_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] change
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1_d;
      logic s2_d;
      logic s3_d;
      always_comb begin
        s1_d = async_in[i];
        s2_d = s1_q[i];
        s3_d = s2_q[i];
      end
      always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
          s1_q[i] <= 1'h0;
          s2_q[i] <= 1'h0;
          s3_q[i] <= 1'h0;
        end else begin
          s1_q[i] <= s1_d;
          s2_q[i] <= s2_d;
          s3_q[i] <= s3_d;
        end
      end
    end
  endgenerate

  // Only the second and third stages are compared; the first feeds the second alone.
  assign level = s3_q;
  assign change = s2_q ^ s3_q;

endmodule // srap_sync

// ### verilog/srap_tx.sv
// Falling-edge transmit stage of the serial link.
`timescale 1ns/1ps
module srap_tx (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic load,
  input wire logic [7:0] rd_word,
  input wire logic [7:0] status_word,
  input wire logic [2:0] bit_cnt,
  input wire logic in_cmd,
  output logic data_bit,
  output logic drive
);

  logic [7:0] tx_q;
  logic [7:0] tx_d;
  logic [2:0] idx_q;
  logic [2:0] idx_d;
  logic cmd_q;
  logic cmd_d;
  logic drive_q;
  logic drive_d;

  // Everything here changes on falling edges only; select high resets it all.
  always_comb begin
    idx_d = bit_cnt;
    cmd_d = in_cmd;
    drive_d = drive_q;
    tx_d = {tx_q[6:0], 1'h0};
    if (load) begin
      tx_d = rd_word;
      drive_d = 1'h1;
    end
  end

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      tx_q <= srap_pkg::SRAP_BYTE_ZERO;
      idx_q <= srap_pkg::SRAP_CNT_ZERO;
      cmd_q <= 1'h1;
      drive_q <= 1'h0;
    end else begin
      tx_q <= tx_d;
      idx_q <= idx_d;
      cmd_q <= cmd_d;
      drive_q <= drive_d;
    end
  end

  // During the command byte the status word goes out, most significant bit first.
  assign data_bit = cmd_q ? status_word[srap_pkg::SRAP_BIT_LAST - idx_q] : tx_q[7];
  assign drive = drive_q;

endmodule // srap_tx

// ### verilog/srap_port.sv
// SPI register access port: serial slave link and system-side access strobes.
`timescale 1ns/1ps
module srap_port (
  input wire logic clock,
  input wire logic rstn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  output logic miso_out,
  output logic miso_oe,
  input wire logic full_duplex_wr,
  input wire logic full_duplex_wdata,
  output logic full_duplex_select,
  input wire logic peripheral_mode,
  input wire logic chip_soft_reset,
  output logic ack_status_bit,
  input wire logic [7:0] status_in,
  output logic cycle_active,
  output logic [4:0] reg_addr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic reg_pop,
  output logic reg_wr,
  output logic [7:0] reg_wdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Link side, rising edges of the serial clock.

  srap_pkg::srap_phase_type phase_q;
  srap_pkg::srap_phase_type phase_d;
  logic [2:0] bit_cnt_q;
  logic [2:0] bit_cnt_d;
  logic [6:0] rx_q;
  logic [6:0] rx_d;
  logic [7:0] rx_full;
  logic [4:0] addr_q;
  logic [4:0] addr_d;
  logic dir_q;
  logic dir_d;
  logic ack_q;
  logic ack_d;
  logic [7:0] wdata_q;
  logic [7:0] wdata_d;
  logic load_q;
  logic load_d;
  logic cmd_tgl_q;
  logic cmd_tgl_d;
  logic fetch_tgl_q;
  logic fetch_tgl_d;
  logic pop_tgl_q;
  logic pop_tgl_d;
  logic wr_tgl_q;
  logic wr_tgl_d;

  always_comb begin
    rx_full = {rx_q, mosi_in};
    rx_d = rx_full[6:0];
    bit_cnt_d = bit_cnt_q + srap_pkg::SRAP_CNT_STEP;
    phase_d = phase_q;
    addr_d = addr_q;
    dir_d = dir_q;
    ack_d = ack_q;
    wdata_d = wdata_q;
    load_d = 1'h0;
    cmd_tgl_d = cmd_tgl_q;
    fetch_tgl_d = fetch_tgl_q;
    pop_tgl_d = pop_tgl_q;
    wr_tgl_d = wr_tgl_q;
    case (phase_q)
      srap_pkg::SRAP_PH_CMD: begin
        if (bit_cnt_q == srap_pkg::SRAP_ADDR_DONE_CNT) begin
          // Bits 7..3 are in; bit 2 comes next and is never decoded.
          addr_d = rx_full[srap_pkg::SRAP_ADDR_W-1:0];
          fetch_tgl_d = ~fetch_tgl_q;
        end
        if (bit_cnt_q == srap_pkg::SRAP_BIT_LAST) begin
          dir_d = rx_full[srap_pkg::SRAP_DIR_BIT];
          ack_d = rx_full[srap_pkg::SRAP_ACK_BIT];
          cmd_tgl_d = ~cmd_tgl_q;
          phase_d = srap_pkg::SRAP_PH_DATA;
          if (rx_full[srap_pkg::SRAP_DIR_BIT] != srap_pkg::SRAP_DIR_WRITE) begin
            load_d = 1'h1;
            pop_tgl_d = ~pop_tgl_q;
          end
        end
      end
      srap_pkg::SRAP_PH_DATA: begin
        // The address stays as captured for every byte of the burst.
        if (dir_q == srap_pkg::SRAP_DIR_WRITE) begin
          if (bit_cnt_q == srap_pkg::SRAP_BIT_LAST) begin
            wdata_d = rx_full;
            wr_tgl_d = ~wr_tgl_q;
          end
        end else begin
          if (bit_cnt_q == srap_pkg::SRAP_ADDR_DONE_CNT) begin
            fetch_tgl_d = ~fetch_tgl_q;
          end
          if (bit_cnt_q == srap_pkg::SRAP_BIT_LAST) begin
            load_d = 1'h1;
            pop_tgl_d = ~pop_tgl_q;
          end
        end
      end
      default: begin
        phase_d = srap_pkg::SRAP_PH_CMD;
      end
    endcase
  end

  // Select high holds the link in reset, dropping the command context.
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      phase_q <= srap_pkg::SRAP_PH_CMD;
      bit_cnt_q <= srap_pkg::SRAP_CNT_ZERO;
      rx_q <= 7'h00;
      addr_q <= srap_pkg::SRAP_ADDR_ZERO;
      dir_q <= 1'h0;
      ack_q <= 1'h0;
      load_q <= 1'h0;
    end else begin
      phase_q <= phase_d;
      bit_cnt_q <= bit_cnt_d;
      rx_q <= rx_d;
      addr_q <= addr_d;
      dir_q <= dir_d;
      ack_q <= ack_d;
      load_q <= load_d;
    end
  end

  // Event toggles and the write word survive select so no event is lost.
  always_ff @(posedge sck or negedge rstn) begin
    if (!rstn) begin
      wdata_q <= srap_pkg::SRAP_BYTE_ZERO;
      cmd_tgl_q <= 1'h0;
      fetch_tgl_q <= 1'h0;
      pop_tgl_q <= 1'h0;
      wr_tgl_q <= 1'h0;
    end else begin
      wdata_q <= wdata_d;
      cmd_tgl_q <= cmd_tgl_d;
      fetch_tgl_q <= fetch_tgl_d;
      pop_tgl_q <= pop_tgl_d;
      wr_tgl_q <= wr_tgl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link side, falling edges and pin drivers.

  logic tx_bit;
  logic tx_drive;
  logic [7:0] rd_hold_q;
  logic [7:0] status_hold_q;
  logic fdup_q;

  srap_tx u_tx (
    .sck(sck),
    .cs_n(cs_n),
    .load(load_q),
    .rd_word(rd_hold_q),
    .status_word(status_hold_q),
    .bit_cnt(bit_cnt_q),
    .in_cmd(phase_q == srap_pkg::SRAP_PH_CMD),
    .data_bit(tx_bit),
    .drive(tx_drive)
  );

  // Half duplex turns MOSI around for read data and never drives MISO.
  assign mosi_out = tx_bit;
  assign mosi_oe = ~fdup_q & ~cs_n & tx_drive;
  assign miso_out = tx_bit;
  assign miso_oe = fdup_q & ~cs_n;

  ////////////////////////////////////////////////////////////////////////////
  // Crossing into the system clock.

  logic [srap_pkg::SRAP_EV_W-1:0] ev_raw;
  logic [srap_pkg::SRAP_EV_W-1:0] ev_level;
  logic [srap_pkg::SRAP_EV_W-1:0] ev_change;

  assign ev_raw[srap_pkg::SRAP_EV_ACTIVE] = ~cs_n;
  assign ev_raw[srap_pkg::SRAP_EV_CMD] = cmd_tgl_q;
  assign ev_raw[srap_pkg::SRAP_EV_FETCH] = fetch_tgl_q;
  assign ev_raw[srap_pkg::SRAP_EV_POP] = pop_tgl_q;
  assign ev_raw[srap_pkg::SRAP_EV_WR] = wr_tgl_q;

  srap_sync #(
    .WIDTH(srap_pkg::SRAP_EV_W)
  ) u_sync (
    .clock(clock),
    .rstn(rstn),
    .async_in(ev_raw),
    .level(ev_level),
    .change(ev_change)
  );

  ////////////////////////////////////////////////////////////////////////////
  // System side: register access strobes and control bits.

  logic fdup_d;
  logic ack_stat_q;
  logic ack_stat_d;
  logic [4:0] reg_addr_q;
  logic [4:0] reg_addr_d;
  logic [7:0] reg_wdata_q;
  logic [7:0] reg_wdata_d;
  logic [7:0] rd_hold_d;
  logic [7:0] status_hold_d;
  logic reg_rd_q;
  logic reg_rd_d;
  logic reg_pop_q;
  logic reg_pop_d;
  logic reg_wr_q;
  logic reg_wr_d;
  logic active_q;
  logic active_d;

  always_comb begin
    fdup_d = fdup_q;
    if (full_duplex_wr) begin
      fdup_d = full_duplex_wdata;
    end
    // The soft reset clears the acknowledge bit but leaves the duplex choice alone.
    ack_stat_d = ack_stat_q;
    if (chip_soft_reset) begin
      ack_stat_d = 1'h0;
    end else if (ev_change[srap_pkg::SRAP_EV_CMD] && peripheral_mode) begin
      ack_stat_d = ack_q;
    end
    active_d = ev_level[srap_pkg::SRAP_EV_ACTIVE];
    // Status is frozen while a cycle runs so the link sees a stable word.
    status_hold_d = status_hold_q;
    if (!active_d && !active_q) begin
      status_hold_d = status_in;
    end
    reg_addr_d = reg_addr_q;
    reg_rd_d = 1'h0;
    reg_pop_d = ev_change[srap_pkg::SRAP_EV_POP];
    reg_wr_d = 1'h0;
    reg_wdata_d = reg_wdata_q;
    if (ev_change[srap_pkg::SRAP_EV_FETCH]) begin
      reg_addr_d = addr_q;
      reg_rd_d = 1'h1;
    end
    if (ev_change[srap_pkg::SRAP_EV_WR]) begin
      reg_wr_d = 1'h1;
      reg_wdata_d = wdata_q;
    end
    // Read data is taken in the cycle after the fetch strobe and then held.
    rd_hold_d = rd_hold_q;
    if (reg_rd_q) begin
      rd_hold_d = reg_rdata;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      fdup_q <= srap_pkg::SRAP_FDUP_POR;
      ack_stat_q <= 1'h0;
      active_q <= 1'h0;
      status_hold_q <= srap_pkg::SRAP_BYTE_ZERO;
      reg_addr_q <= srap_pkg::SRAP_ADDR_ZERO;
      reg_rd_q <= 1'h0;
      reg_pop_q <= 1'h0;
      reg_wr_q <= 1'h0;
      reg_wdata_q <= srap_pkg::SRAP_BYTE_ZERO;
      rd_hold_q <= srap_pkg::SRAP_BYTE_ZERO;
    end else begin
      fdup_q <= fdup_d;
      ack_stat_q <= ack_stat_d;
      active_q <= active_d;
      status_hold_q <= status_hold_d;
      reg_addr_q <= reg_addr_d;
      reg_rd_q <= reg_rd_d;
      reg_pop_q <= reg_pop_d;
      reg_wr_q <= reg_wr_d;
      reg_wdata_q <= reg_wdata_d;
      rd_hold_q <= rd_hold_d;
    end
  end

  assign full_duplex_select = fdup_q;
  assign ack_status_bit = ack_stat_q;
  assign cycle_active = active_q;
  assign reg_addr = reg_addr_q;
  assign reg_rd = reg_rd_q;
  assign reg_pop = reg_pop_q;
  assign reg_wr = reg_wr_q;
  assign reg_wdata = reg_wdata_q;

endmodule // srap_port

// ### testbench/srap_port_properties.sv
// Concurrent checks on the ports of the SPI register access port.
`timescale 1ns/1ps
module srap_port_properties (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic full_duplex_wr,
  input wire logic full_duplex_wdata,
  input wire logic full_duplex_select,
  input wire logic peripheral_mode,
  input wire logic chip_soft_reset,
  input wire logic ack_status_bit,
  input wire logic reg_rd,
  input wire logic reg_pop,
  input wire logic reg_wr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  a_miso_enable: assert property (miso_oe == (full_duplex_select & ~cs_n))
    else $error("miso enable does not follow mode and select");
  a_mosi_release: assert property (mosi_oe |-> !full_duplex_select && !cs_n)
    else $error("mosi driven outside a half duplex cycle");
  a_fdup_write: assert property (full_duplex_wr |=> full_duplex_select == $past(full_duplex_wdata))
    else $error("full duplex select not written");
  a_fdup_hold: assert property (!full_duplex_wr |=> $stable(full_duplex_select))
    else $error("full duplex select changed without a write");
  a_ack_clear: assert property (chip_soft_reset |=> !ack_status_bit)
    else $error("soft reset did not clear ack status");
  a_ack_quiet: assert property (!peripheral_mode && !chip_soft_reset |=> $stable(ack_status_bit))
    else $error("ack status changed outside peripheral mode");
  a_rd_pulse: assert property (reg_rd |=> !reg_rd)
    else $error("read strobe longer than one cycle");
  a_wr_pulse: assert property (reg_wr |=> !reg_wr [*8])
    else $error("write strobes too close");
  a_pop_pulse: assert property (reg_pop |=> !reg_pop [*8])
    else $error("pop strobes too close");

  c_write: cover property (reg_wr);
  c_pop: cover property (reg_pop);
  c_ack: cover property ($rose(ack_status_bit));
endmodule // srap_port_properties

bind srap_port srap_port_properties u_props (
  .clock(clock), .rstn(rstn), .cs_n(cs_n), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .full_duplex_wr(full_duplex_wr), .full_duplex_wdata(full_duplex_wdata),
  .full_duplex_select(full_duplex_select), .peripheral_mode(peripheral_mode),
  .chip_soft_reset(chip_soft_reset), .ack_status_bit(ack_status_bit),
  .reg_rd(reg_rd), .reg_pop(reg_pop), .reg_wr(reg_wr)
);

// ### testbench/srap_master.sv
// SPI master model that drives the link pins of the port.
`timescale 1ns/1ps
module srap_master (
  output logic sck,
  output logic cs_n,
  output logic mosi_in,
  input wire logic mosi_out,
  input wire logic mosi_oe,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic fdup
);
  logic cpol = 1'h0;
  logic m_bit = 1'h0;
  logic m_oe = 1'h0;
  logic last = 1'h0;
  logic miso_line;

  // A released line shows the inverse of its last value.
  assign mosi_in = mosi_oe ? mosi_out : (m_oe ? m_bit : ~last);
  assign miso_line = miso_oe ? miso_out : ~last;

  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
  end

  task automatic start();
    sck = cpol;
    #10 cs_n = 1'h0;
    #10;
  endtask

  task automatic xfer(input logic [7:0] tx, input logic drv, input int n,
                      output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      sck = 1'h0;
      m_oe = drv;
      m_bit = tx[i];
      #7.5 sck = 1'h1;
      rx[i] = fdup ? miso_line : mosi_in;
      last = rx[i];
      #7.5;
    end
  endtask

  task automatic stop();
    sck = cpol;
    #5 m_oe = 1'h0;
    cs_n = 1'h1;
    #60;
  endtask
endmodule // srap_master

// ### testbench/tb.sv
// Self-checking bench for the SPI register access port.
`timescale 1ns/1ps
module tb;
  logic clock, rstn, sck, cs_n, mosi_in, mosi_out, mosi_oe, miso_out, miso_oe;
  logic full_duplex_wr, full_duplex_wdata, full_duplex_select, peripheral_mode;
  logic chip_soft_reset, ack_status_bit, cycle_active, reg_rd, reg_pop, reg_wr;
  logic [7:0] status_in, reg_rdata, reg_wdata, rx;
  logic [4:0] reg_addr;
  logic [7:0] mem [32];
  logic [7:0] fifo [4];
  logic [1:0] ptr = 2'h0;
  logic [12:0] wq [$];
  logic [7:0] wd [3] = '{8'hA5, 8'h5A, 8'hC3};
  int bad_count = 0;
  int checked = 0;

  srap_port u_dut (
    .clock(clock), .rstn(rstn), .sck(sck), .cs_n(cs_n), .mosi_in(mosi_in),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
    .full_duplex_wr(full_duplex_wr), .full_duplex_wdata(full_duplex_wdata),
    .full_duplex_select(full_duplex_select), .peripheral_mode(peripheral_mode),
    .chip_soft_reset(chip_soft_reset), .ack_status_bit(ack_status_bit),
    .status_in(status_in), .cycle_active(cycle_active), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_pop(reg_pop), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata)
  );

  srap_master u_m (
    .sck(sck), .cs_n(cs_n), .mosi_in(mosi_in), .mosi_out(mosi_out),
    .mosi_oe(mosi_oe), .miso_out(miso_out), .miso_oe(miso_oe),
    .fdup(full_duplex_select)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Register file and FIFO standing behind the port.
  assign reg_rdata = (reg_addr == 5'h01) ? fifo[ptr] : mem[reg_addr];

  always @(posedge clock) begin
    if (reg_pop) begin
      ptr <= ptr + 2'h1;
    end
    if (reg_wr) begin
      wq.push_back({reg_addr, reg_wdata});
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic set_fd(input logic v);
    @(posedge clock);
    full_duplex_wr <= 1'h1;
    full_duplex_wdata <= v;
    @(posedge clock);
    full_duplex_wr <= 1'h0;
    repeat (2) @(posedge clock);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    #20000;
    bad_count++;
    finish_test();
  end

  initial begin
    rstn = 1'h0;
    full_duplex_wr = 1'h0;
    full_duplex_wdata = 1'h0;
    peripheral_mode = 1'h0;
    chip_soft_reset = 1'h0;
    status_in = 8'h00;
    foreach (mem[i]) mem[i] = 8'h00;
    mem[9] = 8'h96;
    fifo = '{8'h11, 8'h22, 8'h33, 8'h44};
    repeat (3) @(posedge clock);
    rstn <= 1'h1;
    repeat (4) @(posedge clock);
    chk(full_duplex_select, 13'h0000);
    chk(ack_status_bit, 13'h0000);
    @(posedge clock);
    chip_soft_reset <= 1'h1;
    set_fd(1'h1);
    chip_soft_reset <= 1'h0;
    chk(full_duplex_select, 13'h0001);
    set_fd(1'h0);
    $display("test reset values done");

    peripheral_mode <= 1'h1;
    u_m.start();
    u_m.xfer(8'h1B, 1'h1, 8, rx);
    foreach (wd[i]) u_m.xfer(wd[i], 1'h1, 8, rx);
    u_m.stop();
    chk(13'(wq.size()), 13'h0003);
    foreach (wd[i]) chk(wq[i], {5'h03, wd[i]});
    chk(ack_status_bit, 13'h0001);
    $display("test write burst done");

    u_m.cpol = 1'h1;
    u_m.start();
    u_m.xfer(8'h48, 1'h1, 8, rx);
    u_m.xfer(8'h00, 1'h0, 8, rx);
    chk(rx, 13'h0096);
    u_m.stop();
    chk(ack_status_bit, 13'h0000);
    u_m.cpol = 1'h0;
    $display("test half duplex read done");

    @(posedge clock);
    status_in <= 8'h3C;
    ptr <= 2'h0;
    set_fd(1'h1);
    u_m.start();
    u_m.xfer(8'h08, 1'h1, 8, rx);
    chk(rx, 13'h003C);
    chk(cycle_active, 13'h0001);
    for (int i = 0; i < 3; i++) begin
      u_m.xfer(8'h00, 1'h1, 8, rx);
      chk(rx, {5'h00, fifo[i]});
    end
    u_m.stop();
    chk(cycle_active, 13'h0000);
    set_fd(1'h0);
    $display("test full duplex fifo read done");

    wq.delete();
    u_m.start();
    u_m.xfer(8'h1A, 1'h1, 8, rx);
    u_m.xfer(8'hFF, 1'h1, 4, rx);
    u_m.stop();
    chk(13'(wq.size()), 13'h0000);
    u_m.start();
    u_m.xfer(8'h2A, 1'h1, 8, rx);
    u_m.xfer(8'h77, 1'h1, 8, rx);
    u_m.stop();
    chk(13'(wq.size()), 13'h0001);
    chk(wq[0], {5'h05, 8'h77});
    $display("test aborted byte done");
    finish_test();
  end
endmodule // tb
